// ===== rtl/sfc_pkg.sv
package sfc_pkg;

    // Command codes, bits 7 to 5 of the received word
    localparam logic [2:0] CMD_STATUS   = 3'h0;
    localparam logic [2:0] CMD_MASK     = 3'h1;
    localparam logic [2:0] CMD_MODE     = 3'h2;
    localparam logic [2:0] CMD_CLEAR    = 3'h3;
    localparam logic [2:0] CMD_DEADTIME = 3'h4;

    // Field positions in the received word
    localparam int CMD_MSB   = 7;
    localparam int CMD_LSB   = 5;
    localparam int HALF_BIT  = 4;
    localparam int WORD_BITS = 8;

    localparam int MODE_LOCK_BIT  = 0;
    localparam int MODE_FULL_BIT  = 1;
    localparam int MODE_DESAT_BIT = 3;
    localparam int DT_CAL_BIT     = 0;

    // Fault flag positions: low half then high half
    localparam int FLT_OVERTEMP = 0;
    localparam int FLT_DESAT    = 1;
    localparam int FLT_SUPPLY   = 2;
    localparam int FLT_OVERCUR  = 3;
    localparam int FLT_PHASE    = 4;
    localparam int FLT_FRAMING  = 5;
    localparam int FLT_WRLOCK   = 6;
    localparam int FLT_RESET    = 7;

    localparam logic [3:0] MASK_RESET     = 4'hf;
    localparam logic [7:0] DEADTIME_RESET = 8'hff;
    localparam logic [7:0] FAULT_RESET    = 8'h80;
    localparam int         DT_SHIFT       = 4;
    localparam int         CAL_W          = 12;

    typedef struct packed {
        logic       desat_ignore;
        logic       simultaneous_drive;
        logic       lock;
    } sfc_mode_s;

endpackage

// ===== rtl/sfc_unit.sv
`timescale 1ns/10ps
module sfc_unit
(
    // Clock and reset
    input  wire logic       REF_CLK,
    input  wire logic       RST,
    // Serial port, sampled on the reference clock
    input  wire logic       SCLK,
    input  wire logic       CS_N,
    input  wire logic       SI,
    output logic            SO,
    // Fault sources and drive state
    input  wire logic [3:0] FAULT_LOW,
    input  wire logic [1:0] FAULT_DRIVE,
    input  wire logic       ENABLE_IN_A,
    input  wire logic       ENABLE_IN_B,
    input  wire logic [2:0] LOW_SIDE_IN,
    input  wire logic [2:0] HIGH_SIDE_IN,
    // Outputs
    output logic            INT,
    output logic [2:0] HIGH_SIDE_OK,
    output logic            DRIVERS_OFF,
    output logic            SIMULTANEOUS_DRIVE,
    output logic [7:0] DEADTIME
);

////////////////////////////////////////////////////////////////////////////////

    logic                sclk_d_reg;
    logic                cs_d_reg;
    logic [7:0]          shift_in_reg;
    logic [7:0]          shift_out_reg;
    logic [2:0]          bit_cnt_reg;
    logic                any_bits_reg;
    logic [7:0]          fault_reg;
    logic [7:0]          snap_reg;
    logic [7:0]          changed_reg;
    logic [3:0]          mask_low_reg;
    logic [3:0]          mask_high_reg;
    sfc_pkg::sfc_mode_s  mode_reg;
    logic [1:0]          status_sel_reg;
    logic                cal_pending_reg;
    logic                cal_run_reg;
    logic [sfc_pkg::CAL_W-1:0] cal_cnt_reg;
    logic [7:0]          deadtime_reg;
    logic [2:0]          primed_reg;
    logic                protect_reg;

    logic                sclk_rise;
    logic                cs_fall;
    logic                cs_rise;
    logic                frame_ok;
    logic [7:0]          word;
    logic [2:0]          cmd;
    logic [7:0]          fault_now;
    logic [7:0]          set_ev;
    logic [7:0]          clr_vec;
    logic                wr_cmd;
    logic [7:0]          status_word;

    assign sclk_rise = SCLK && !sclk_d_reg;
    assign cs_fall   = !CS_N && cs_d_reg;
    assign cs_rise   = CS_N && !cs_d_reg;
    assign frame_ok  = any_bits_reg && (bit_cnt_reg == 3'h0);
    assign word      = shift_in_reg;
    assign cmd       = word[sfc_pkg::CMD_MSB:sfc_pkg::CMD_LSB];
    assign wr_cmd    = cmd == sfc_pkg::CMD_MASK || cmd == sfc_pkg::CMD_MODE ||
                       cmd == sfc_pkg::CMD_DEADTIME;

////////////////////////////////////////////////////////////////////////////////
// Serial shift, MSB first

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            sclk_d_reg <= 1'b0;
            cs_d_reg   <= 1'b1;
        end
        else
        begin
            sclk_d_reg <= SCLK;
            cs_d_reg   <= CS_N;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            shift_in_reg <= 8'h00;
            bit_cnt_reg  <= 3'h0;
            any_bits_reg <= 1'b0;
        end
        else if (cs_fall)
        begin
            bit_cnt_reg  <= 3'h0;
            any_bits_reg <= 1'b0;
        end
        else if (!CS_N && sclk_rise)
        begin
            shift_in_reg <= {shift_in_reg[6:0], SI};
            bit_cnt_reg  <= bit_cnt_reg + 3'h1;
            any_bits_reg <= 1'b1;
        end
    end

    // Status 0 carries the latched faults; others show settings
    always_comb
    begin
        unique case (status_sel_reg)
            2'h0:    status_word = fault_reg;
            2'h1:    status_word = {mask_high_reg, mask_low_reg};
            2'h2:    status_word = {4'h0, mode_reg.desat_ignore, 1'b0, mode_reg.simultaneous_drive, mode_reg.lock};
            default: status_word = deadtime_reg;
        endcase
    end

    // Return word loads at frame start, shifts out on falling SCLK
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            shift_out_reg <= 8'h00;
        else if (cs_fall)
            shift_out_reg <= status_word;
        else if (!CS_N && !SCLK && sclk_d_reg)
            shift_out_reg <= {shift_out_reg[6:0], 1'b0};
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            SO <= 1'b0;
        else
            SO <= cs_fall ? status_word[7] : shift_out_reg[7];
    end

////////////////////////////////////////////////////////////////////////////////
// Command execution at rising chip select

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            status_sel_reg <= 2'h0;
        else if (cs_rise && frame_ok && !cal_run_reg)
            status_sel_reg <= (cmd == sfc_pkg::CMD_STATUS) ? word[1:0] : 2'h0;
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            mask_low_reg  <= sfc_pkg::MASK_RESET;
            mask_high_reg <= sfc_pkg::MASK_RESET;
            mode_reg      <= '0;
        end
        else if (cs_rise && frame_ok && !cal_run_reg && !mode_reg.lock)
        begin
            if (cmd == sfc_pkg::CMD_MASK && !word[sfc_pkg::HALF_BIT])
                mask_low_reg <= word[3:0];
            if (cmd == sfc_pkg::CMD_MASK && word[sfc_pkg::HALF_BIT])
                mask_high_reg <= word[3:0];
            if (cmd == sfc_pkg::CMD_MODE)
            begin
                mode_reg.desat_ignore       <= word[sfc_pkg::MODE_DESAT_BIT];
                mode_reg.simultaneous_drive <= word[sfc_pkg::MODE_FULL_BIT];
                mode_reg.lock               <= word[sfc_pkg::MODE_LOCK_BIT];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Fault latches

    assign fault_now = {1'b0, 2'b00, FAULT_DRIVE[1], FAULT_LOW[3], FAULT_LOW[2],
                        FAULT_LOW[1] | FAULT_DRIVE[0], FAULT_LOW[0]};

    always_comb
    begin
        set_ev = fault_now;
        set_ev[sfc_pkg::FLT_FRAMING] = cs_rise && !frame_ok && !cal_run_reg;
        set_ev[sfc_pkg::FLT_WRLOCK]  = cs_rise && frame_ok && !cal_run_reg && mode_reg.lock && wr_cmd;
        set_ev[sfc_pkg::FLT_RESET]   = !(ENABLE_IN_A && ENABLE_IN_B) && 1'b0;
        clr_vec = 8'h00;
        if (cs_rise && frame_ok && !cal_run_reg && cmd == sfc_pkg::CMD_CLEAR)
        begin
            if (word[sfc_pkg::HALF_BIT])
                clr_vec[7:4] = word[3:0];
            else
                clr_vec[3:0] = word[3:0];
        end
        clr_vec = clr_vec & ~changed_reg;
    end

    // Snapshot at frame start to detect changes mid-frame
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            snap_reg    <= 8'h00;
            changed_reg <= 8'h00;
        end
        else if (cs_fall)
        begin
            snap_reg    <= fault_reg;
            changed_reg <= 8'h00;
        end
        else if (!CS_N)
            changed_reg <= changed_reg | (fault_reg ^ snap_reg) | set_ev;
    end

    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_latch
            always_ff @(posedge REF_CLK or posedge RST)
            begin
                if (RST)
                    fault_reg[i] <= sfc_pkg::FAULT_RESET[i];
                else if (set_ev[i])
                    fault_reg[i] <= 1'b1; // Set beats a clear in the same cycle
                else if (clr_vec[i])
                    fault_reg[i] <= 1'b0;
            end
        end
    endgenerate

    // Level output; stays up while any enabled latch is set
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            INT <= 1'b0;
        else
            INT <= |(fault_reg & {mask_high_reg, mask_low_reg});
    end

////////////////////////////////////////////////////////////////////////////////
// Deadtime calibration

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            cal_pending_reg <= 1'b0;
            cal_run_reg     <= 1'b0;
            cal_cnt_reg     <= '0;
            deadtime_reg    <= sfc_pkg::DEADTIME_RESET;
        end
        else if (cal_run_reg)
        begin
            if (cs_rise)
            begin
                cal_run_reg  <= 1'b0;
                deadtime_reg <= cal_cnt_reg[sfc_pkg::DT_SHIFT+7:sfc_pkg::DT_SHIFT];
            end
            else
                cal_cnt_reg <= cal_cnt_reg + 1'b1;
        end
        else if (cs_fall && cal_pending_reg)
        begin
            cal_pending_reg <= 1'b0;
            cal_run_reg     <= 1'b1;
            cal_cnt_reg     <= '0;
        end
        else if (cs_rise && frame_ok && !mode_reg.lock && cmd == sfc_pkg::CMD_DEADTIME)
        begin
            if (word[sfc_pkg::DT_CAL_BIT])
                cal_pending_reg <= 1'b1;
            else
                deadtime_reg <= 8'h00;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Drive permissions

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            primed_reg  <= 3'h0;
            protect_reg <= 1'b0;
        end
        else if (!(ENABLE_IN_A && ENABLE_IN_B))
        begin
            primed_reg  <= 3'h0;
            protect_reg <= 1'b0;
        end
        else
        begin
            if (!mode_reg.desat_ignore && (FAULT_LOW[1] || FAULT_DRIVE[1]) || FAULT_LOW[2])
            begin
                protect_reg <= 1'b1;
                primed_reg  <= 3'h0;
            end
            else if (protect_reg && clr_vec != 8'h00)
                protect_reg <= 1'b0;
            else if (!protect_reg)
                primed_reg <= primed_reg | LOW_SIDE_IN;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            HIGH_SIDE_OK       <= 3'h0;
            DRIVERS_OFF        <= 1'b1;
            SIMULTANEOUS_DRIVE <= 1'b0;
            DEADTIME           <= sfc_pkg::DEADTIME_RESET;
        end
        else
        begin
            HIGH_SIDE_OK       <= primed_reg & HIGH_SIDE_IN & {3{!protect_reg}};
            DRIVERS_OFF        <= protect_reg || !(ENABLE_IN_A && ENABLE_IN_B);
            SIMULTANEOUS_DRIVE <= mode_reg.simultaneous_drive;
            DEADTIME           <= deadtime_reg;
        end
    end

////////////////////////////////////////////////////////////////////////////////

    mode_locked_a: assert property (@(posedge REF_CLK) disable iff (RST)
        mode_reg.lock |=> mode_reg.lock && $stable(mask_low_reg))
        else $error("mask changed after lock");

    framing_flag_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (cs_rise && !frame_ok && !cal_run_reg) |=> fault_reg[sfc_pkg::FLT_FRAMING])
        else $error("framing error not latched");

    irq_level_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (|(fault_reg & {mask_high_reg, mask_low_reg})) |=> INT)
        else $error("interrupt dropped with enabled fault");

    clear_edge_a: assert property (@(posedge REF_CLK) disable iff (RST)
        ($fell(fault_reg[sfc_pkg::FLT_OVERTEMP])) |-> $past(cs_rise))
        else $error("fault cleared outside chip select rise");

    status_read_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (cs_rise && frame_ok && !cal_run_reg && cmd == sfc_pkg::CMD_STATUS) |=>
        $stable(mask_low_reg) && $stable(mask_high_reg) && $stable(mode_reg))
        else $error("status read changed settings");

    irq_masked_a: assert property (@(posedge REF_CLK) disable iff (RST)
        !(|(fault_reg & {mask_high_reg, mask_low_reg})) |=> !INT)
        else $error("interrupt raised without enabled fault");

endmodule

// ===== verif/sfc_host_model.sv
`timescale 1ns/10ps
module sfc_host_model
(
    // Clock
    input  wire logic REF_CLK,
    // Serial port
    output logic      SCLK,
    output logic      CS_N,
    output logic      SI,
    input  wire logic SO
);
    initial
    begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        SI   = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask

    // Reply is whatever the last eight clocks carried
    task automatic xfer(input logic [15:0] tx, input int n, output logic [7:0] rx);
        wait_clk(1);
        CS_N <= 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            wait_clk(4);
            SI <= tx[i];
            wait_clk(4);
            SCLK <= 1'b1;
            rx = {rx[6:0], SO};
            wait_clk(4);
            SCLK <= 1'b0;
        end
        wait_clk(4);
        CS_N <= 1'b1;
        SI   <= 1'b0;
        wait_clk(8);
    endtask

    // Sixteen times the wanted deadtime, no clocks inside
    task automatic cal_pulse(input int cycles);
        wait_clk(1);
        CS_N <= 1'b0;
        wait_clk(cycles);
        CS_N <= 1'b1;
        wait_clk(8);
    endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic       ref_clk;
    logic       rst;
    logic       sclk;
    logic       cs_n;
    logic       si;
    logic       so;
    logic [3:0] fault_low;
    logic [1:0] fault_drive;
    logic       enable_in_a;
    logic       enable_in_b;
    logic [2:0] low_side_in;
    logic [2:0] high_side_in;
    logic       int_out;
    logic [2:0] hs_ok;
    logic       drv_off;
    logic       simultaneous_drive;
    logic [7:0] deadtime;
    logic [7:0] rx;
    int         fail_count;
    int         num_checks;

    sfc_host_model host (.REF_CLK(ref_clk), .SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so));

    sfc_unit uut (.REF_CLK(ref_clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so),
        .FAULT_LOW(fault_low), .FAULT_DRIVE(fault_drive), .ENABLE_IN_A(enable_in_a),
        .ENABLE_IN_B(enable_in_b), .LOW_SIDE_IN(low_side_in), .HIGH_SIDE_IN(high_side_in),
        .INT(int_out), .HIGH_SIDE_OK(hs_ok), .DRIVERS_OFF(drv_off),
        .SIMULTANEOUS_DRIVE(simultaneous_drive), .DEADTIME(deadtime));

    always #50 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Reply belongs to the previous command
    task automatic cmd(input logic [7:0] c, input logic [7:0] exp);
        host.xfer({8'h00, c}, 8, rx);
        check(rx, exp);
    endtask

    task automatic pulse_fault(input int b);
        fault_low[b] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        fault_low[b] <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic summarize();
        if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        summarize();
    end

    initial
    begin
        ref_clk = 1'b0;
        rst = 1'b1;
        fault_low = 4'h0;
        fault_drive = 2'h0;
        enable_in_a = 1'b0;
        enable_in_b = 1'b0;
        low_side_in = 3'h0;
        high_side_in = 3'h0;
        fail_count = 0;
        num_checks = 0;
        do_reset();
        check(int_out, 8'h01);
        cmd(8'h00, 8'h80);
        cmd(8'h01, 8'h80);
        cmd(8'h1f, 8'hff);
        cmd(8'h02, 8'hff);
        cmd(8'h00, 8'h00);
        cmd(8'h79, 8'h80);
        cmd(8'h00, 8'h00);
        check(int_out, 8'h00);
        // Low mask off, then a masked overtemperature
        cmd(8'h20, 8'h00);
        cmd(8'h01, 8'h00);
        pulse_fault(0);
        cmd(8'h00, 8'hf0);
        check(int_out, 8'h00);
        cmd(8'h21, 8'h01);
        check(int_out, 8'h01);
        // Supply fault held through its own clear
        fault_low[2] <= 1'b1;
        cmd(8'h25, 8'h05);
        cmd(8'h61, 8'h05);
        cmd(8'h00, 8'h04);
        check(int_out, 8'h01);
        cmd(8'h64, 8'h04);
        fault_low[2] <= 1'b0;
        cmd(8'h00, 8'h04);
        check(int_out, 8'h01);
        cmd(8'h64, 8'h04);
        cmd(8'h00, 8'h00);
        check(int_out, 8'h00);
        // Seven-bit clear is discarded and flagged
        pulse_fault(0);
        host.xfer(16'h0061, 7, rx);
        host.xfer(16'h0000, 8, rx);
        cmd(8'h00, 8'h21);
        cmd(8'h61, 8'h21);
        cmd(8'h72, 8'h20);
        cmd(8'h00, 8'h00);
        // Daisy chain: only the trailing byte counts
        pulse_fault(0);
        host.xfer(16'h6100, 16, rx);
        cmd(8'h00, 8'h01);
        fork
            host.xfer(16'h0061, 8, rx);
            begin
                repeat (40) @(posedge ref_clk);
                pulse_fault(0);
            end
        join
        check(rx, 8'h01);
        cmd(8'h00, 8'h01);
        cmd(8'h61, 8'h01);
        cmd(8'h00, 8'h00);
        // Calibrated deadtime: 488 cycles gives 30
        cmd(8'h81, 8'h00);
        host.cal_pulse(488);
        check(deadtime, 8'h1e);
        cmd(8'h03, 8'h00);
        cmd(8'h00, 8'h1e);
        // Bootstrap priming, then desaturation shutdown
        enable_in_a <= 1'b1;
        enable_in_b <= 1'b1;
        high_side_in <= 3'h7;
        repeat (6) @(posedge ref_clk);
        check(hs_ok, 8'h00);
        low_side_in[1] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        low_side_in[1] <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check(hs_ok, 8'h02);
        pulse_fault(1);
        check(drv_off, 8'h01);
        cmd(8'h00, 8'h02);
        cmd(8'h62, 8'h02);
        // Mode with lock, then a refused mask write
        cmd(8'h43, 8'h00);
        check(simultaneous_drive, 8'h01);
        cmd(8'h30, 8'h00);
        cmd(8'h40, 8'h40);
        cmd(8'h01, 8'h40);
        cmd(8'h00, 8'hf5);
        check(simultaneous_drive, 8'h01);
        do_reset();
        check(deadtime, 8'hff);
        check(simultaneous_drive, 8'h00);
        cmd(8'h01, 8'h80);
        cmd(8'h00, 8'hff);
        summarize();
    end
endmodule
